/* spt_cfg.svh */
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH

// word, slave-select and buffer sizes
`define SPT_WORD_W        16
`define SPT_SS_N          7
`define SPT_FIFO_D        8

// port control register field positions
`define SPT_CTL_TRANSFER_INITIATE_SELECT_LO  0
`define SPT_CTL_SZ        4
`define SPT_CTL_GM        5
`define SPT_CTL_CPHA      10
`define SPT_CTL_CPOL      11
`define SPT_CTL_MSTR      12
`define SPT_CTL_EN        14

// transfer initiate select codes
`define SPT_TRANSFER_INITIATE_SELECT_READ    2'h0
`define SPT_TRANSFER_INITIATE_SELECT_WRITE   2'h1

// receive latency in core_clk cycles after the last sampling edge
`define SPT_RX_LAT        3
// smallest usable half period of sck, in core_clk cycles
`define SPT_BAUD_MIN      16'h0002
// index of the final sck edge of a 16-bit word
`define SPT_LAST_EDGE     5'h1F
`define SPT_LAST_BIT      4'hF

`endif

/* spt_pkg.sv */
package spt_pkg;
  `include "spt_cfg.svh"

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_TAIL = 2'b11
  } spt_state_t;

  typedef struct packed {
    logic       en;
    logic       mstr;
    logic       cpha;
    logic       cpol;
    logic       sz;
    logic       gm;
    logic [1:0] transfer_initiate_select;
  } spt_ctl_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spt_pins_out_t;

  // split the port control register into its fields
  function automatic spt_ctl_t spt_decode(input logic [15:0] c);
    spt_ctl_t r;
    r.en    = c[`SPT_CTL_EN];
    r.mstr  = c[`SPT_CTL_MSTR];
    r.cpha  = c[`SPT_CTL_CPHA];
    r.cpol  = c[`SPT_CTL_CPOL];
    r.sz    = c[`SPT_CTL_SZ];
    r.gm    = c[`SPT_CTL_GM];
    r.transfer_initiate_select = c[`SPT_CTL_TRANSFER_INITIATE_SELECT_LO +: 2];
    return r;
  endfunction
endpackage

/* spt_top.sv */
`timescale 1ns/1ps
`include "spt_cfg.svh"

module spt_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output      logic         in_ready,
  output      logic         out_valid,
  output      logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // honest full and empty straight from the fill count
  assign in_ready  = cnt_reg != D[AW:0];
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset; only words under the count are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers wrap because the depth is a power of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + AW'(1);
      end
      if (pop) begin
        rp_reg <= rp_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module spt_top (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic [15:0]              port_control_register,
  input  wire logic [15:0]              baud_divider,
  input  wire logic [`SPT_SS_N-1:0]     slave_select_enable_bits,
  input  wire logic [`SPT_SS_N-1:0]     slave_select_level_bits,
  input  wire logic                     tx_write,
  input  wire logic [`SPT_WORD_W-1:0]   tx_wdata,
  output      logic                     tx_ready,
  input  wire logic                     rx_read,
  output      logic [`SPT_WORD_W-1:0]   receive_buffer,
  output      logic                     receive_full_flag,
  output      logic                     transmit_empty_flag,
  output      logic                     transfer_finished_flag,
  output      logic                     transmit_collision_flag,
  input  wire logic                     transmit_collision_flag_w1c,
  output      logic                     port_irq,
  output      logic [`SPT_SS_N-1:0]     ss_out_n,
  output      spt_pkg::spt_pins_out_t   pins_out,
  input  wire logic                     sck_i,
  input  wire logic                     mosi_i,
  input  wire logic                     miso_i,
  input  wire logic                     slave_select_input_n
);
  import spt_pkg::*;

  spt_ctl_t                 ctl;
  spt_state_t               state_reg;
  logic [15:0]              tmr_reg;
  logic [15:0]              half_m1;
  logic [4:0]               edge_cnt_reg;
  logic                     sck_reg;
  logic                     sck_prev_reg;
  logic                     ss_prev_reg;
  logic [`SPT_WORD_W-1:0]   sh_reg;
  logic [`SPT_WORD_W-1:0]   rx_sh_reg;
  logic [`SPT_WORD_W-1:0]   cap_reg;
  logic [`SPT_WORD_W-1:0]   last_tx_reg;
  logic [`SPT_WORD_W-1:0]   rx_buf_reg;
  logic [`SPT_WORD_W-1:0]   tx_head;
  logic [`SPT_WORD_W-1:0]   load_word;
  logic [`SPT_RX_LAT-1:0]   done_pipe_reg;
  logic                     rxs_reg;
  logic                     transfer_finished_flag_reg;
  logic                     transmit_collision_flag_reg;
  logic                     irq_reg;
  logic                     is_master;
  logic                     is_slave;
  logic                     tx_avail;
  logic                     half_exp;
  logic                     m_start;
  logic                     m_edge;
  logic                     s_edge;
  logic                     s_fall;
  logic                     edge_ev;
  logic                     edge_lead;
  logic                     sample_ev;
  logic                     shift_ev;
  logic                     word_done;
  logic                     load_now;
  logic                     rx_evt;
  logic                     rx_take;
  logic                     in_bit;
  logic                     ss_act;

  // control fields, clock phase taken from bit ten
  assign ctl       = spt_decode(port_control_register);
  assign is_master = ctl.en & ctl.mstr;
  assign is_slave  = ctl.en & ~ctl.mstr;

  // transmit buffer: an 8-word queue whose head feeds the shift register
  spt_fifo #(
    .W (`SPT_WORD_W),
    .D (`SPT_FIFO_D)
  ) u_txq (
    .clk       (core_clk),
    .rst_n     (nrst),
    .in_valid  (tx_write),
    .in_data   (tx_wdata),
    .in_ready  (tx_ready),
    .out_valid (tx_avail),
    .out_data  (tx_head),
    .out_ready (load_now)
  );

  // half sck period in core cycles; divider values below two are clamped
  assign half_m1  = ((baud_divider < `SPT_BAUD_MIN) ? `SPT_BAUD_MIN : baud_divider) - 16'h0001;
  assign half_exp = tmr_reg == half_m1;

  // master launch per initiate select; dma and reserved codes never launch
  always_comb begin
    m_start = 1'b0;
    if (is_master && state_reg == ST_IDLE) begin
      case (ctl.transfer_initiate_select)
        `SPT_TRANSFER_INITIATE_SELECT_READ:  m_start = rx_read;
        `SPT_TRANSFER_INITIATE_SELECT_WRITE: m_start = tx_avail;
        default:          m_start = 1'b0;
      endcase
    end
  end

  // edge events: master makes them from the timer, slave sees them on sck_i
  assign m_edge    = is_master & (state_reg == ST_LEAD | state_reg == ST_RUN) & half_exp;
  assign s_edge    = is_slave & ~slave_select_input_n & (sck_i != sck_prev_reg);
  assign s_fall    = is_slave & ss_prev_reg & ~slave_select_input_n;
  assign edge_ev   = m_edge | s_edge;
  assign edge_lead = ~edge_cnt_reg[0];
  assign sample_ev = edge_ev & (edge_lead ^ ctl.cpha);
  // the first leading edge under phase one only presents the loaded msb
  assign shift_ev  = edge_ev & ~(edge_lead ^ ctl.cpha) & (edge_cnt_reg != 5'h00);
  // last bit in and out closes the word, for master and slave alike
  assign word_done = sample_ev & (edge_cnt_reg[4:1] == `SPT_LAST_BIT);
  assign in_bit    = is_master ? miso_i : mosi_i;

  // shift register load: master launch, slave select fall, or first edge
  assign load_now = m_start | (s_fall & ~ctl.cpha)
                  | (s_edge & ctl.cpha & (edge_cnt_reg == 5'h00));

  // empty queue sends zeros or repeats the last word sent
  assign load_word = tx_avail ? tx_head : (ctl.sz ? '0 : last_tx_reg);

  // master sequencer
  always_ff @(posedge core_clk) begin
    if (!nrst || !is_master) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (m_start) begin
            state_reg <= ST_LEAD;
          end
        end
        // sck held idle for a half period before the first edge
        ST_LEAD: begin
          if (half_exp) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (m_edge && edge_cnt_reg == `SPT_LAST_EDGE) begin
            state_reg <= ST_TAIL;
          end
        end
        ST_TAIL: begin
          if (half_exp) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // half period timer, restarted at launch and on every expiry
  always_ff @(posedge core_clk) begin
    if (!nrst || m_start || half_exp || state_reg == ST_IDLE) begin
      tmr_reg <= 16'h0000;
    end else begin
      tmr_reg <= tmr_reg + 16'h0001;
    end
  end

  // edge counter; a released slave select restarts the slave count
  always_ff @(posedge core_clk) begin
    if (!nrst || m_start || (is_slave && slave_select_input_n)) begin
      edge_cnt_reg <= 5'h00;
    end else if (edge_ev) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  // sck output and the slave-side history used for edge detection
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      ss_prev_reg  <= 1'b1;
    end else begin
      sck_prev_reg <= sck_i;
      ss_prev_reg  <= slave_select_input_n;
      // the expiry that ends the lead half period is itself the first edge
      if (m_edge) begin
        sck_reg <= ~sck_reg;
      end else if (state_reg == ST_IDLE || state_reg == ST_LEAD) begin
        sck_reg <= ctl.cpol;
      end
    end
  end

  // transmit and receive shifters, msb first
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh_reg      <= '0;
      rx_sh_reg   <= '0;
      cap_reg     <= '0;
      last_tx_reg <= '0;
    end else begin
      if (load_now) begin
        sh_reg <= load_word;
      end else if (shift_ev) begin
        sh_reg <= {sh_reg[`SPT_WORD_W-2:0], 1'b0};
      end
      if (load_now && tx_avail) begin
        last_tx_reg <= tx_head;
      end
      if (sample_ev) begin
        rx_sh_reg <= {rx_sh_reg[`SPT_WORD_W-2:0], in_bit};
      end
      // snapshot so a following word cannot disturb the pending one
      if (word_done) begin
        cap_reg <= {rx_sh_reg[`SPT_WORD_W-2:0], in_bit};
      end
    end
  end

  // fixed latency from the last sampling edge, independent of baud and mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      done_pipe_reg <= '0;
    end else begin
      done_pipe_reg <= {done_pipe_reg[`SPT_RX_LAT-2:0], word_done};
    end
  end
  assign rx_evt  = done_pipe_reg[`SPT_RX_LAT-1];
  // a read in the same cycle frees the buffer for the arriving word
  assign rx_take = rx_evt & (~rxs_reg | rx_read | ctl.gm);

  // receive buffer and receive-full flag; a new word wins over a read
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_buf_reg <= '0;
      rxs_reg    <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_buf_reg <= cap_reg;
      end
      if (rx_take) begin
        rxs_reg <= 1'b1;
      end else if (rx_read) begin
        rxs_reg <= 1'b0;
      end
    end
  end

  // transfer-finished: slave with receive-full, master half period after last edge;
  // at small dividers the master flag can lead receive-full
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      transfer_finished_flag_reg <= 1'b0;
    end else if ((is_slave && rx_evt)
                 || (state_reg == ST_TAIL && half_exp)) begin
      transfer_finished_flag_reg <= 1'b1;
    end else if (load_now) begin
      transfer_finished_flag_reg <= 1'b0;
    end
  end

  // collision flag; undetectable for a phase-zero slave, set beats clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      transmit_collision_flag_reg <= 1'b0;
    end else if (tx_write && load_now && !(is_slave && !ctl.cpha)) begin
      transmit_collision_flag_reg <= 1'b1;
    end else if (transmit_collision_flag_w1c) begin
      transmit_collision_flag_reg <= 1'b0;
    end
  end

  // port interrupt, registered so it trails its flag by one cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      case (ctl.transfer_initiate_select)
        `SPT_TRANSFER_INITIATE_SELECT_READ:  irq_reg <= ctl.en & rxs_reg;
        `SPT_TRANSFER_INITIATE_SELECT_WRITE: irq_reg <= ctl.en & ~tx_avail;
        default:          irq_reg <= 1'b0;
      endcase
    end
  end

  // slave selects: phase zero follows the transfer, phase one the level bits
  assign ss_act = is_master & (state_reg != ST_IDLE);
  for (genvar i = 0; i < `SPT_SS_N; i++) begin : g_ss
    assign ss_out_n[i] = ~(is_master & slave_select_enable_bits[i])
                       | (ctl.cpha ? slave_select_level_bits[i] : ~ss_act);
  end

  // pin drive and status outputs
  assign pins_out.sck_o   = sck_reg;
  assign pins_out.sck_oe  = is_master;
  assign pins_out.mosi_o  = sh_reg[`SPT_WORD_W-1];
  assign pins_out.mosi_oe = is_master;
  assign pins_out.miso_o  = sh_reg[`SPT_WORD_W-1];
  assign pins_out.miso_oe = is_slave & ~slave_select_input_n;

  assign receive_buffer          = rx_buf_reg;
  assign receive_full_flag       = rxs_reg;
  assign transmit_empty_flag     = ~tx_avail;
  assign transfer_finished_flag  = transfer_finished_flag_reg;
  assign transmit_collision_flag = transmit_collision_flag_reg;
  assign port_irq                = irq_reg;

  // checks on the design's own outputs
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence rx_wait_s;
    word_done ##1 (!rx_read && !(ctl.gm == 1'b0 && rxs_reg)) [*3];
  endsequence

  sequence tail_end_s;
    state_reg == ST_TAIL && half_exp;
  endsequence

  transmit_collision_flag_set_a: assert property (
    tx_write && load_now && !(is_slave && !ctl.cpha) |=> transmit_collision_flag_reg)
    else $error("collision not flagged");
  transmit_collision_flag_hold_a: assert property (
    transmit_collision_flag_reg && !transmit_collision_flag_w1c |=> transmit_collision_flag_reg)
    else $error("collision flag dropped without clear");
  slave_nocol_a: assert property (
    is_slave && !ctl.cpha && !transmit_collision_flag_reg |=> !transmit_collision_flag_reg)
    else $error("collision flagged by phase zero slave");
  master_start_a: assert property (
    m_start |=> state_reg == ST_LEAD)
    else $error("master launch missed");
  ss_active_a: assert property (
    state_reg == ST_LEAD && !ctl.cpha |-> ss_out_n == ~slave_select_enable_bits)
    else $error("slave select not active at start");
  sck_lead_a: assert property (
    state_reg == ST_LEAD && $stable(ctl.cpol) |-> sck_reg == ctl.cpol)
    else $error("sck moved during lead half cycle");
  slave_start_a: assert property (
    s_fall && !ctl.cpha && !rx_evt |=> !transfer_finished_flag_reg)
    else $error("slave start did not open a transfer");
  rx_latency_a: assert property (
    rx_wait_s |=> rxs_reg)
    else $error("receive-full late");
  irq_follow_a: assert property (
    $rose(rxs_reg) && ctl.en && ctl.transfer_initiate_select == `SPT_TRANSFER_INITIATE_SELECT_READ |=> port_irq)
    else $error("interrupt not one cycle after receive-full");
  slave_transfer_finished_flag_a: assert property (
    is_slave && $rose(rxs_reg) |-> transfer_finished_flag_reg)
    else $error("slave finished flag not with receive-full");
  master_transfer_finished_flag_a: assert property (
    tail_end_s |=> transfer_finished_flag_reg && state_reg == ST_IDLE)
    else $error("master finished flag missing");
  rx_first_a: assert property (
    $rose(transfer_finished_flag_reg) && is_master && baud_divider >= 16'h0004 |-> done_pipe_reg == '0)
    else $error("finished flag ahead of receive-full");
  rx_overwrite_a: assert property (
    rx_evt && ctl.gm |=> rx_buf_reg == $past(cap_reg))
    else $error("full buffer not overwritten");
  rx_discard_a: assert property (
    rx_evt && rxs_reg && !ctl.gm && !rx_read |=> $stable(rx_buf_reg))
    else $error("full buffer changed");
  tx_zero_a: assert property (
    load_now && !tx_avail && ctl.sz |=> sh_reg == '0)
    else $error("zero word not sent");
  tx_irq_a: assert property (
    ctl.en && ctl.transfer_initiate_select == `SPT_TRANSFER_INITIATE_SELECT_WRITE && !tx_avail |=> port_irq)
    else $error("write mode interrupt missing");
endmodule

/* spt_peer.sv */
`timescale 1ns/1ps
// far-side spi device: slave on the dut's sck, or master through send
module spt_peer (
  input  wire logic clk,
  input  wire logic cpha,
  input  wire logic cpol,
  input  wire logic slv_on,
  input  wire logic sck_in,
  input  wire logic mosi_in,
  input  wire logic miso_in,
  output      logic miso_out,
  output      logic sck_m,
  output      logic mosi_m,
  output      logic ss_m_n
);
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  logic [15:0] sh      = 16'h0000;
  logic [15:0] rx      = 16'h0000;
  logic [15:0] rxm     = 16'h0000;
  int          n       = 0;

  // a released miso shows the inverse, so a stale bit never passes
  assign miso_out = slv_on ? sh[15] : ~sh[15];

  // master role idles with sck still at level zero
  initial begin
    sck_m = 1'b0;
    mosi_m = 1'b0;
    ss_m_n = 1'b1;
  end

  // phase zero frame start: msb must be ready before the first edge
  always @(posedge slv_on) begin
    n = 0;
    sh = tx_word;
  end

  // slave role: sample on one edge kind, shift on the other
  always @(posedge sck_in or negedge sck_in) begin
    if (slv_on) begin
      if ((sck_in !== cpol) != cpha) rx = {rx[14:0], mosi_in};
      else if (cpha && n == 0) sh = tx_word;
      else sh = sh << 1;
      n++;
      if (n == 32) begin
        n = 0;
        rx_word = rx;
        sh = tx_word;
      end
    end
  end

  // master role: one word, h core cycles per sck half period
  task automatic send(input logic [15:0] w, input int h);
    int k;
    @(negedge clk);
    ss_m_n = 1'b0;
    mosi_m = cpha ? ~mosi_m : w[15];
    repeat (h) @(negedge clk);
    for (k = 0; k < 32; k++) begin
      sck_m = ~sck_m;
      if (((k % 2) == 0) != cpha) rxm = {rxm[14:0], miso_in};
      else if (cpha) mosi_m = w[15 - k / 2];
      else if (k < 31) mosi_m = w[14 - k / 2];
      repeat (h) @(negedge clk);
    end
    ss_m_n = 1'b1;
    mosi_m = ~mosi_m;
  endtask
endmodule

/* spt_top_test.sv */
`timescale 1ns/1ps
module spt_top_test;
  import spt_pkg::*;
  localparam logic [15:0] EN   = 16'h4000;
  localparam logic [15:0] MS   = 16'h1000;
  localparam logic [15:0] PH   = 16'h0400;
  localparam logic [15:0] CPL  = 16'h0800;
  localparam logic [15:0] GETM = 16'h0020;
  localparam logic [15:0] ZERO = 16'h0010;
  localparam logic [15:0] WR   = 16'h0001;
  logic          core_clk, nrst, tx_write, rx_read, transmit_collision_flag_w1c;
  logic [15:0]   ctl, baud, tx_wdata, rbuf;
  logic [6:0]    se_bits, lv_bits, ss_out_n;
  logic          tx_ready, rfull, tempty, tdone, tcol, port_irq;
  spt_pins_out_t pins_out;
  logic          sck_m, mosi_m, ss_m_n, miso_p, slv_on;
  int            err_count, n_tests, t_r, t_f, t_i, i;

  // peer slave listens while the dut master frames it under phase zero, and whenever the dut is master under phase one
  assign slv_on = ctl[12] & (ctl[10] | ~ss_out_n[0]);

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  spt_top i_spt_top (.core_clk(core_clk), .nrst(nrst), .port_control_register(ctl),
    .baud_divider(baud), .slave_select_enable_bits(se_bits),
    .slave_select_level_bits(lv_bits), .tx_write(tx_write), .tx_wdata(tx_wdata),
    .tx_ready(tx_ready), .rx_read(rx_read), .receive_buffer(rbuf),
    .receive_full_flag(rfull), .transmit_empty_flag(tempty),
    .transfer_finished_flag(tdone), .transmit_collision_flag(tcol),
    .transmit_collision_flag_w1c(transmit_collision_flag_w1c), .port_irq(port_irq), .ss_out_n(ss_out_n),
    .pins_out(pins_out), .sck_i(sck_m), .mosi_i(mosi_m), .miso_i(miso_p),
    .slave_select_input_n(ss_m_n));

  spt_peer i_spt_peer (.clk(core_clk), .cpha(ctl[10]), .cpol(ctl[11]), .slv_on(slv_on),
    .sck_in(pins_out.sck_o), .mosi_in(pins_out.mosi_o), .miso_in(pins_out.miso_o),
    .miso_out(miso_p), .sck_m(sck_m), .mosi_m(mosi_m), .ss_m_n(ss_m_n));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cfg(input logic [15:0] c, input logic [15:0] b);
    @(negedge core_clk);
    ctl = c;
    baud = b;
  endtask

  task automatic push(input logic [15:0] w);
    @(negedge core_clk);
    tx_write = 1'b1;
    tx_wdata = w;
    @(negedge core_clk);
    tx_write = 1'b0;
  endtask

  task automatic rd;
    @(negedge core_clk);
    rx_read = 1'b1;
    @(negedge core_clk);
    rx_read = 1'b0;
  endtask

  // bounded wait for both end flags, noting the cycle each one rose
  task automatic xfer_wait(input int skip);
    int c;
    t_r = -1;
    t_f = -1;
    t_i = -1;
    repeat (skip) @(negedge core_clk);
    for (c = 0; c < 3000; c++) begin
      @(negedge core_clk);
      if (t_r < 0 && rfull === 1'b1) t_r = c;
      if (t_f < 0 && tdone === 1'b1) t_f = c;
      if (t_i < 0 && port_irq === 1'b1) t_i = c;
      if (t_r >= 0 && t_f >= 0 && c > t_r + 2 && c > t_f + 2) break;
    end
    chk("done", 16'(t_r >= 0 && t_f >= 0), 16'h0001);
  endtask

  // watchdog, far beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    ctl = 16'h0000;
    baud = 16'h0004;
    se_bits = 7'h7F;
    lv_bits = 7'h55;
    tx_write = 1'b0;
    tx_wdata = 16'h0000;
    rx_read = 1'b0;
    transmit_collision_flag_w1c = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    chk("rst_rbuf", rbuf, 16'h0000);
    chk("rst_flags", 16'({rfull, tdone, tcol, port_irq}), 16'h0000);
    chk("rst_empty", 16'({tempty, tx_ready}), 16'h0003);
    // master, write launched, phase one; flag order follows the baud
    for (i = 0; i < 2; i++) begin
      cfg(EN | MS | PH | WR, i ? 16'h0002 : 16'h0006);
      repeat (2) @(negedge core_clk);
      chk("irq_wr", 16'(port_irq), 16'h0001);
      chk("ss_lvl", 16'(ss_out_n), 16'h0055);
      i_spt_peer.tx_word = 16'h3C5A + 16'(i);
      push(16'hA5C3 + 16'(i));
      xfer_wait(3);
      chk("rbuf", rbuf, 16'h3C5A + 16'(i));
      chk("peer_rx", i_spt_peer.rx_word, 16'hA5C3 + 16'(i));
      chk("oe_mst", 16'({pins_out.sck_oe, pins_out.mosi_oe, pins_out.miso_oe}), 16'h0006);
      // receive-full trails the last sampling edge by three core cycles
      chk("order", 16'(t_f - t_r), baud - 16'h0003);
      rd();
    end
    // full receive buffer: keep or overwrite
    for (i = 0; i < 2; i++) begin
      cfg(EN | MS | PH | WR | (i ? GETM : 16'h0000), 16'h0002);
      i_spt_peer.tx_word = 16'h1111;
      push(16'hAAAA);
      xfer_wait(3);
      i_spt_peer.tx_word = 16'h2222;
      push(16'h5555);
      xfer_wait(3);
      chk("rbuf_gm", rbuf, i ? 16'h2222 : 16'h1111);
      rd();
    end
    // master, read launched, phase zero, empty transmit queue
    for (i = 0; i < 2; i++) begin
      cfg(EN | MS | (i ? ZERO | CPL : 16'h0000), 16'h0004);
      se_bits = 7'h05;
      i_spt_peer.tx_word = 16'h1234 + 16'(i);
      rd();
      chk("ss_out", 16'(ss_out_n), 16'h007A);
      for (int j = 0; j < 3; j++) begin
        chk("sck_lead", 16'(pins_out.sck_o), 16'(i));
        @(negedge core_clk);
      end
      xfer_wait(0);
      chk("rbuf_rd", rbuf, 16'h1234 + 16'(i));
      chk("peer_fill", i_spt_peer.rx_word, i ? 16'h0000 : 16'h5555);
      chk("irq_lat", 16'(t_i - t_r), 16'h0001);
    end
    // buffer write in the very load cycle
    @(negedge core_clk);
    rx_read = 1'b1;
    tx_write = 1'b1;
    tx_wdata = 16'hC0DE;
    @(negedge core_clk);
    rx_read = 1'b0;
    tx_write = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("tcol", 16'(tcol), 16'h0001);
    transmit_collision_flag_w1c = 1'b1;
    @(negedge core_clk);
    transmit_collision_flag_w1c = 1'b0;
    @(negedge core_clk);
    chk("tcol_clr", 16'(tcol), 16'h0000);
    xfer_wait(0);
    // slave, phase zero then one, with a write at the load
    for (i = 0; i < 2; i++) begin
      cfg(EN | (i ? PH : 16'h0000), 16'h0004);
      rd();
      fork
        i_spt_peer.send(16'h6E29 + 16'(i), 4);
        begin
          repeat (i ? 5 : 1) @(negedge core_clk);
          tx_write = 1'b1;
          tx_wdata = i ? 16'h7777 : 16'hBEEF;
          @(negedge core_clk);
          tx_write = 1'b0;
          chk("oe_slv", 16'({pins_out.sck_oe, pins_out.mosi_oe, pins_out.miso_oe}),
              16'h0001);
        end
        xfer_wait(i ? 8 : 3);
      join
      chk("rbuf_slv", rbuf, 16'h6E29 + 16'(i));
      chk("peer_miso", i_spt_peer.rxm, i ? 16'hBEEF : 16'hC0DE);
      chk("same_cyc", 16'(t_f - t_r), 16'h0000);
      chk("tcol_slv", 16'(tcol), 16'(i));
    end
    // fill the queue until refused, then drain it with the master stalling
    for (i = 1; i < 8; i++) push(16'h1000 + 16'(i));
    chk("full", 16'(tx_ready), 16'h0000);
    push(16'hDEAD);
    for (i = 0; i < 8; i++) begin
      repeat (4) @(negedge core_clk);
      i_spt_peer.send(16'h0000, 4);
      chk("drain", i_spt_peer.rxm, i ? 16'h1000 + 16'(i) : 16'h7777);
    end
    chk("empty", 16'({tempty, tx_ready}), 16'h0003);
    end_of_test();
  end
endmodule
